// File: rtl/mxu_pkg.sv
package mxu_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int DATA_W = 8; // data byte width
	localparam int ADDR_W = 11; // program address width
	localparam int STACK_DEPTH = 8; // nesting levels
	localparam int PTR_W = 3; // stack pointer width

	// ****************************************
	// operation codes
	// ****************************************
	typedef enum logic [5:0] {
		MXU_NOP = 6'h00,
		MXU_ADD_AM = 6'h01,
		MXU_ADD_AX = 6'h02,
		MXU_ADDM = 6'h03,
		MXU_ADC_AM = 6'h04,
		MXU_ADCM = 6'h05,
		MXU_AND_AM = 6'h06,
		MXU_AND_AX = 6'h07,
		MXU_ANDM = 6'h08,
		MXU_OR_AM = 6'h09,
		MXU_OR_AX = 6'h0A,
		MXU_ORM = 6'h0B,
		MXU_CALL = 6'h0C,
		MXU_CLR_M = 6'h0D,
		MXU_WDCLR = 6'h0E,
		MXU_WDPRE1 = 6'h0F,
		MXU_WDPRE2 = 6'h10,
		MXU_INV_M = 6'h11,
		MXU_INV_A = 6'h12,
		MXU_DECADJ = 6'h13,
		MXU_DEC_M = 6'h14,
		MXU_DEC_A = 6'h15,
		MXU_INC_M = 6'h16,
		MXU_INC_A = 6'h17,
		MXU_HALT = 6'h18,
		MXU_JUMP = 6'h19,
		MXU_XFER_AM = 6'h1A,
		MXU_XFER_AX = 6'h1B,
		MXU_XFER_MA = 6'h1C,
		MXU_SUBEXIT = 6'h1D,
		MXU_SUBEXIT_X = 6'h1E,
		MXU_IRQEXIT = 6'h1F,
		MXU_ROL_M = 6'h20,
		MXU_ROL_A = 6'h21
	} mxu_op_e;

	// ****************************************
	// constants
	// ****************************************
	localparam logic [7:0] ZERO_BYTE = 8'h00; // clear value
	localparam logic [7:0] ONE_BYTE = 8'h01; // step for inc and dec
	localparam logic [3:0] BCD_MAX = 4'h9; // largest decimal digit
	localparam logic [7:0] ADJ_LO = 8'h06; // low digit correction
	localparam logic [7:0] ADJ_HI = 8'h60; // high digit correction
	localparam logic [10:0] PC_STEP = 11'h001; // return address offset
	localparam int MSB = 7; // top bit of a byte
	localparam int NIB = 4; // nibble width

endpackage : mxu_pkg

// File: rtl/mxu_alu.sv
`timescale 1ns/1ns
// ****************************************
// byte arithmetic with flag outputs
// ****************************************
module mxu_alu (
	// operands
	input wire logic [7:0] opA,
	input wire logic [7:0] opB,
	input wire logic carryIn,
	// results
	output logic [7:0] sum,
	output logic carryOut,
	output logic halfOut,
	output logic wrapOut
);
	logic [4:0] lowSum; // low nibble with carry
	logic [8:0] fullSum; // byte with carry

	// plain adder; half-carry from bit 3, carry from bit 7
	always_comb begin
		lowSum = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
		fullSum = {1'b0, opA} + {1'b0, opB} + {8'h00, carryIn};
		sum = fullSum[7:0];
		carryOut = fullSum[8]; // RULE22
		halfOut = lowSum[4]; // RULE22
		// wrap when both signs match and the result sign differs
		wrapOut = (opA[7] == opB[7]) && (sum[7] != opA[7]); // RULE22
	end
endmodule : mxu_alu

// File: rtl/mxu_exec.sv
`timescale 1ns/1ns
// Operation
// RULE1: add with carry updates four flags
// RULE2: add without carry updates four flags
// RULE3: and operation changes only zero flag
// RULE4: or operation changes only zero flag
// RULE5: call pushes pc plus one, two cycles
// RULE6: clear byte writes zero
// RULE7: watchdog clear resets counter, both flags
// RULE8: preclears work only when alternated
// RULE9: invert byte, zero flag only
// RULE10: decimal adjust into byte, carry only
// RULE11: decrement, zero flag only
// RULE12: increment, zero flag only
// RULE13: halt stops, clears watchdog, sets powerdown
// RULE14: jump loads pc, two cycles
// RULE15: moves leave flags unchanged
// RULE16: nop only advances
// RULE17: return pops pc
// RULE18: return loads immediate into accumulator
// RULE19: interrupt return pops pc, sets enable
// RULE20: rotate left byte, bit 7 to 0
// RULE21: rotate left into accumulator only
// RULE22: flag meanings zero carry half wrap
module mxu_exec #(
	parameter int STACK_DEPTH = mxu_pkg::STACK_DEPTH
) (
	// clock and control
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clkEn,
	// instruction from decode
	input wire logic opValid,
	input wire logic [5:0] opCode,
	input wire logic [7:0] immData,
	input wire logic [10:0] targetAddr,
	// data byte read value
	input wire logic [7:0] memRdata,
	// wake from power down
	input wire logic wakeReq,
	// watchdog counter ran out, same clock
	input wire logic watchdogTimeout,
	// data byte write
	output logic memWe,
	output logic [7:0] memWdata,
	// architectural state
	output logic [7:0] acc,
	output logic [10:0] pc,
	output logic zeroFlag,
	output logic carryFlag,
	output logic halfCarryFlag,
	output logic signedWrapFlag,
	output logic watchdogExpiryFlag,
	output logic powerdownFlag,
	output logic globalIrqEnable,
	output logic watchdogClear,
	output logic sysClkGate,
	output logic busy
);
	// ****************************************
	// declarations
	// ****************************************
	typedef enum logic [2:0] {
		MXU_RUN = 3'b001, // taking instructions
		MXU_DUMMY = 3'b010, // inserted dummy cycle
		MXU_SLEEP = 3'b100 // clock gated off
	} mxu_state_e;

	mxu_state_e state; // sequencer state
	mxu_state_e next_state; // sequencer next
	mxu_pkg::mxu_op_e op; // decoded op
	logic [10:0] stack [STACK_DEPTH]; // return addresses
	logic [2:0] sp; // stack pointer, next free slot
	logic [2:0] spTop; // index of top entry
	logic lastPre; // last preclear kind seen
	logic preValid; // a preclear is waiting for its partner
	logic take; // an instruction executes this cycle
	logic [7:0] aluB; // adder and logic second operand
	logic aluCin; // adder carry input
	logic [7:0] aluSum; // adder result
	logic aluC; // adder carry
	logic aluH; // adder half carry
	logic aluV; // adder overflow
	logic [7:0] adjVal; // decimal adjust addend
	logic [8:0] adjSum; // decimal adjust result
	logic [7:0] res; // result for dest
	logic wrAcc; // result goes to accumulator
	logic wrMem; // result goes to data byte
	logic updZ; // zero flag follows result
	logic updArith; // four arithmetic flags follow

	// zero test used by the zero flag path
	function automatic logic isZero(input logic [7:0] v);
		return v == mxu_pkg::ZERO_BYTE;
	endfunction : isZero

	assign op = mxu_pkg::mxu_op_e'(opCode);
	assign take = clkEn && opValid && (state == MXU_RUN);
	assign spTop = sp - 3'd1;

	// ****************************************
	// datapath
	// ****************************************
	// adder operand select: immediate forms use immData
	always_comb begin
		aluB = memRdata;
		aluCin = 1'b0;
		unique case (op)
			mxu_pkg::MXU_ADD_AX, mxu_pkg::MXU_AND_AX, mxu_pkg::MXU_OR_AX:
				aluB = immData; // RULE2 RULE3 RULE4
			mxu_pkg::MXU_ADC_AM, mxu_pkg::MXU_ADCM: aluCin = carryFlag; // RULE1
			default: aluB = memRdata;
		endcase
	end

	mxu_alu u_alu (
		.opA(acc),
		.opB(aluB),
		.carryIn(aluCin),
		.sum(aluSum),
		.carryOut(aluC),
		.halfOut(aluH),
		.wrapOut(aluV)
	);

	// decimal adjust: 06 and/or 60 per digit and flags
	always_comb begin
		adjVal = mxu_pkg::ZERO_BYTE;
		if (acc[3:0] > mxu_pkg::BCD_MAX || halfCarryFlag) begin
			adjVal = adjVal | mxu_pkg::ADJ_LO; // RULE10
		end
		if (acc[7:4] > mxu_pkg::BCD_MAX || carryFlag) begin
			adjVal = adjVal | mxu_pkg::ADJ_HI; // RULE10
		end
		adjSum = {1'b0, acc} + {1'b0, adjVal};
	end

	// result and destination per operation
	always_comb begin
		res = mxu_pkg::ZERO_BYTE;
		wrAcc = 1'b0;
		wrMem = 1'b0;
		updZ = 1'b0;
		updArith = 1'b0;
		unique case (op)
			mxu_pkg::MXU_ADD_AM, mxu_pkg::MXU_ADD_AX, mxu_pkg::MXU_ADDM,
			mxu_pkg::MXU_ADC_AM, mxu_pkg::MXU_ADCM: begin
				res = aluSum; // RULE1 RULE2
				wrMem = (op == mxu_pkg::MXU_ADDM || op == mxu_pkg::MXU_ADCM);
				wrAcc = !wrMem;
				updArith = 1'b1;
			end
			mxu_pkg::MXU_AND_AM, mxu_pkg::MXU_AND_AX,
			mxu_pkg::MXU_ANDM: begin
				res = acc & aluB; // RULE3
				wrMem = (op == mxu_pkg::MXU_ANDM);
				wrAcc = !wrMem;
				updZ = 1'b1;
			end
			mxu_pkg::MXU_OR_AM, mxu_pkg::MXU_OR_AX,
			mxu_pkg::MXU_ORM: begin
				res = acc | aluB; // RULE4
				wrMem = (op == mxu_pkg::MXU_ORM);
				wrAcc = !wrMem;
				updZ = 1'b1;
			end
			mxu_pkg::MXU_CLR_M: begin
				res = mxu_pkg::ZERO_BYTE; // RULE6
				wrMem = 1'b1;
			end
			mxu_pkg::MXU_INV_M, mxu_pkg::MXU_INV_A: begin
				res = ~memRdata; // RULE9
				wrMem = (op == mxu_pkg::MXU_INV_M);
				wrAcc = (op == mxu_pkg::MXU_INV_A);
				updZ = 1'b1;
			end
			mxu_pkg::MXU_DECADJ: begin
				res = adjSum[7:0]; // RULE10
				wrMem = 1'b1;
			end
			mxu_pkg::MXU_DEC_M, mxu_pkg::MXU_DEC_A: begin
				res = memRdata - mxu_pkg::ONE_BYTE; // RULE11
				wrMem = (op == mxu_pkg::MXU_DEC_M);
				wrAcc = (op == mxu_pkg::MXU_DEC_A);
				updZ = 1'b1;
			end
			mxu_pkg::MXU_INC_M, mxu_pkg::MXU_INC_A: begin
				res = memRdata + mxu_pkg::ONE_BYTE; // RULE12
				wrMem = (op == mxu_pkg::MXU_INC_M);
				wrAcc = (op == mxu_pkg::MXU_INC_A);
				updZ = 1'b1;
			end
			mxu_pkg::MXU_XFER_AM: begin
				res = memRdata; // RULE15
				wrAcc = 1'b1;
			end
			mxu_pkg::MXU_XFER_AX, mxu_pkg::MXU_SUBEXIT_X: begin
				res = immData; // RULE15 RULE18
				wrAcc = 1'b1;
			end
			mxu_pkg::MXU_XFER_MA: begin
				res = acc; // RULE15
				wrMem = 1'b1;
			end
			mxu_pkg::MXU_ROL_M, mxu_pkg::MXU_ROL_A: begin
				res = {memRdata[mxu_pkg::MSB-1:0], memRdata[mxu_pkg::MSB]}; // RULE20
				wrMem = (op == mxu_pkg::MXU_ROL_M); // RULE20
				wrAcc = (op == mxu_pkg::MXU_ROL_A); // RULE21
			end
			default: res = mxu_pkg::ZERO_BYTE; // nop and control ops
		endcase
	end

	// ****************************************
	// sequencer
	// ****************************************
	// branch ops add a dummy cycle; halt sleeps until wake
	always_comb begin
		next_state = state;
		unique case (state)
			MXU_RUN: begin
				if (take && op inside {mxu_pkg::MXU_CALL, mxu_pkg::MXU_JUMP,
					mxu_pkg::MXU_SUBEXIT, mxu_pkg::MXU_SUBEXIT_X,
					mxu_pkg::MXU_IRQEXIT}) begin
					next_state = MXU_DUMMY; // RULE5 RULE14
				end else if (take && op == mxu_pkg::MXU_HALT) begin
					next_state = MXU_SLEEP; // RULE13
				end
			end
			MXU_DUMMY: next_state = MXU_RUN;
			MXU_SLEEP: if (wakeReq) next_state = MXU_RUN;
			default: next_state = MXU_RUN; // illegal code recovers
		endcase
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= MXU_RUN;
		end else if (clkEn) begin
			state <= next_state;
		end
	end

	// status outputs from the sequencer
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			busy <= 1'b0;
			sysClkGate <= 1'b0;
		end else if (clkEn) begin
			busy <= (next_state != MXU_RUN);
			sysClkGate <= (next_state == MXU_SLEEP); // RULE13
		end
	end

	// ****************************************
	// accumulator, data write and flags
	// ****************************************
	// accumulator and data byte write port
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			acc <= mxu_pkg::ZERO_BYTE;
			memWe <= 1'b0;
			memWdata <= mxu_pkg::ZERO_BYTE;
		end else if (clkEn) begin
			memWe <= take && wrMem;
			if (take && wrMem) memWdata <= res;
			if (take && wrAcc) acc <= res;
		end
	end

	// arithmetic flags; moves and control ops keep them
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			zeroFlag <= 1'b0;
			carryFlag <= 1'b0;
			halfCarryFlag <= 1'b0;
			signedWrapFlag <= 1'b0;
		end else if (take) begin
			if (updZ || updArith) zeroFlag <= isZero(res); // RULE22
			if (updArith) begin
				carryFlag <= aluC; // RULE1 RULE2
				halfCarryFlag <= aluH;
				signedWrapFlag <= aluV;
			end
			// carry only ever sets here, so prior carry is kept
			if (op == mxu_pkg::MXU_DECADJ && adjSum[8]) begin
				carryFlag <= 1'b1; // RULE10
			end
		end
	end

	// ****************************************
	// program counter and stack
	// ****************************************
	// pc advances by one unless a branch loads it
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pc <= '0;
			sp <= '0;
			for (int i = 0; i < STACK_DEPTH; i++) stack[i] <= '0;
		end else if (take) begin
			unique case (op)
				mxu_pkg::MXU_CALL: begin
					stack[sp] <= pc + mxu_pkg::PC_STEP; // RULE5
					sp <= sp + 3'd1; // wraps when nesting overflows
					pc <= targetAddr;
				end
				mxu_pkg::MXU_JUMP: pc <= targetAddr; // RULE14
				mxu_pkg::MXU_SUBEXIT, mxu_pkg::MXU_SUBEXIT_X,
				mxu_pkg::MXU_IRQEXIT: begin
					pc <= stack[spTop]; // RULE17 RULE18 RULE19
					sp <= spTop;
				end
				default: pc <= pc + mxu_pkg::PC_STEP; // RULE16
			endcase
		end
	end

	// global interrupt enable; irq entry is outside this unit
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			globalIrqEnable <= 1'b0;
		end else if (take && op == mxu_pkg::MXU_IRQEXIT) begin
			// a pending request is taken by the irq logic next
			globalIrqEnable <= 1'b1; // RULE19
		end
	end

	// ****************************************
	// watchdog clear and power flags
	// ****************************************
	// a preclear acts only when the other kind came last
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			watchdogExpiryFlag <= 1'b0;
			powerdownFlag <= 1'b0;
			watchdogClear <= 1'b0;
			lastPre <= 1'b0;
			preValid <= 1'b0;
		end else if (clkEn) begin
			watchdogClear <= 1'b0;
			if (take && op == mxu_pkg::MXU_WDCLR) begin
				watchdogClear <= 1'b1; // RULE7
				watchdogExpiryFlag <= 1'b0;
				powerdownFlag <= 1'b0;
			end else if (take && (op == mxu_pkg::MXU_WDPRE1
				|| op == mxu_pkg::MXU_WDPRE2)) begin
				if (preValid && lastPre != (op == mxu_pkg::MXU_WDPRE2)) begin
					watchdogClear <= 1'b1; // RULE8
					watchdogExpiryFlag <= 1'b0;
					powerdownFlag <= 1'b0;
					preValid <= 1'b0;
				end else begin
					preValid <= 1'b1; // repeat restarts the pair
				end
				lastPre <= (op == mxu_pkg::MXU_WDPRE2);
			end else if (take && op == mxu_pkg::MXU_HALT) begin
				watchdogClear <= 1'b1; // RULE13
				watchdogExpiryFlag <= 1'b0;
				powerdownFlag <= 1'b1;
			end
			// an expiry beside a clear wins, so no timeout is lost
			if (watchdogTimeout) watchdogExpiryFlag <= 1'b1;
		end
	end
endmodule : mxu_exec

// File: bench/mxu_exec_assertions.sv
`timescale 1ns/1ns
// ****************************************
// port checks for the execute unit
// ****************************************
module mxu_exec_chk (
	// clock and control
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clkEn,
	// request
	input wire logic opValid,
	input wire logic [5:0] opCode,
	input wire logic [10:0] targetAddr,
	input wire logic [7:0] memRdata,
	input wire logic watchdogTimeout,
	// state
	input wire logic memWe,
	input wire logic [7:0] memWdata,
	input wire logic [7:0] acc,
	input wire logic [10:0] pc,
	input wire logic zeroFlag,
	input wire logic carryFlag,
	input wire logic watchdogExpiryFlag,
	input wire logic powerdownFlag,
	input wire logic globalIrqEnable,
	input wire logic watchdogClear,
	input wire logic sysClkGate,
	input wire logic busy
);
	logic take; // request accepted at this edge
	logic [7:0] rdPrev; // operand seen beside the last request
	assign take = clkEn && opValid && !busy;
	// operand copy, so the rotate can be sliced
	always_ff @(posedge ref_clk) begin
		rdPrev <= memRdata;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	chk_call_two_cycles: assert property (
		take && opCode == mxu_pkg::MXU_CALL |=>
		pc == $past(targetAddr) && busy ##1 !busy)
		else $error("call timing wrong");
	chk_jump_pc: assert property (
		take && opCode == mxu_pkg::MXU_JUMP |=>
		pc == $past(targetAddr) && busy)
		else $error("jump target wrong");
	chk_clear_byte: assert property (
		take && opCode == mxu_pkg::MXU_CLR_M |=> memWe && memWdata == 8'h00)
		else $error("clear byte wrong");
	chk_rotate_byte: assert property (
		take && opCode == mxu_pkg::MXU_ROL_M |=> memWe &&
		memWdata == {rdPrev[6:0], rdPrev[7]} && $stable(carryFlag))
		else $error("rotate wrong");
	chk_invert_acc: assert property (
		take && opCode == mxu_pkg::MXU_INV_A |=> acc == ~rdPrev && !memWe)
		else $error("invert into acc wrong");
	chk_wd_clear: assert property (
		take && opCode == mxu_pkg::MXU_WDCLR && !watchdogTimeout |=>
		watchdogClear &&
		!powerdownFlag && !watchdogExpiryFlag)
		else $error("watchdog clear wrong");
	chk_halt_sleep: assert property (
		take && opCode == mxu_pkg::MXU_HALT && !watchdogTimeout |=>
		sysClkGate && busy &&
		powerdownFlag && !watchdogExpiryFlag && watchdogClear)
		else $error("halt wrong");
	chk_irq_enable: assert property (
		take && opCode == mxu_pkg::MXU_IRQEXIT |=> globalIrqEnable && busy)
		else $error("interrupt return wrong");
	chk_nop_still: assert property (
		take && opCode == mxu_pkg::MXU_NOP |=>
		!memWe && $stable(acc) && $stable(zeroFlag) && $stable(carryFlag))
		else $error("nop changed state");
	chk_expiry_set: assert property (
		clkEn && watchdogTimeout |=> watchdogExpiryFlag)
		else $error("expiry flag not raised");
	// main scenarios reached
	cov_call: cover property (take && opCode == mxu_pkg::MXU_CALL);
	cov_halt: cover property (take && opCode == mxu_pkg::MXU_HALT);
	cov_write: cover property (memWe && memWdata == 8'h00);
endmodule : mxu_exec_chk

bind mxu_exec mxu_exec_chk i_mxu_exec_chk (.ref_clk(ref_clk), .srst(srst),
	.clkEn(clkEn), .opValid(opValid), .opCode(opCode),
	.targetAddr(targetAddr), .memRdata(memRdata), .memWe(memWe),
	.memWdata(memWdata), .acc(acc), .pc(pc), .zeroFlag(zeroFlag),
	.carryFlag(carryFlag), .watchdogExpiryFlag(watchdogExpiryFlag),
	.powerdownFlag(powerdownFlag), .globalIrqEnable(globalIrqEnable),
	.watchdogClear(watchdogClear), .sysClkGate(sysClkGate), .busy(busy),
	.watchdogTimeout(watchdogTimeout));

// File: bench/mxu_mem_model.sv
`timescale 1ns/1ns
// ****************************************
// one addressed data byte
// ****************************************
module mxu_mem_model (
	// clock
	input wire logic ref_clk,
	// bench preload
	input wire logic ldEn,
	input wire logic [7:0] ldData,
	// unit side
	input wire logic memWe,
	input wire logic [7:0] memWdata,
	output logic [7:0] memRdata
);
	// the unit's write wins; bench never loads beside it
	always_ff @(posedge ref_clk) begin
		if (memWe) begin
			memRdata <= memWdata;
		end else if (ldEn) begin
			memRdata <= ldData;
		end
	end
endmodule : mxu_mem_model

// File: bench/tb_mxu_exec.sv
`timescale 1ns/1ns
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin nMismatch++; \
	$display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb_mxu_exec;
	logic ref_clk = 0, srst = 1, opValid = 0, wakeReq = 0, ldEn = 0;
	logic clkEn = 1, watchdogTimeout = 0; // enable and expiry drive
	logic [18:0] held; // acc and pc kept across a freeze
	logic [5:0] opCode = 0; // request code
	logic [7:0] immData = 0, ldData = 0, memRdata, memWdata, acc;
	logic [10:0] targetAddr = 0, pc;
	logic memWe, zeroFlag, carryFlag, halfCarryFlag, signedWrapFlag;
	logic watchdogExpiryFlag, powerdownFlag, globalIrqEnable;
	logic watchdogClear, sysClkGate, busy;
	int nMismatch = 0, nCompared = 0, cycles = 0;
	// row: op, acc in, byte or immediate, acc out, byte out, z c h v
	logic [43:0] rows [25] = '{
		44'h01_FF_01_00_01_E, 44'h04_10_20_31_20_0, 44'h03_70_10_70_80_1,
		44'h02_08_08_10_08_2, 44'h05_80_80_80_00_D, 44'h06_F0_0F_00_0F_D,
		44'h07_3C_0F_0C_0F_5, 44'h08_F0_33_F0_30_5, 44'h09_00_00_00_00_D,
		44'h0A_50_05_55_05_5, 44'h0B_01_80_01_81_5, 44'h0D_12_AB_12_00_5,
		44'h11_00_FF_00_00_D, 44'h12_00_0F_F0_0F_5, 44'h14_77_01_77_00_D,
		44'h15_00_00_FF_00_5, 44'h16_00_FF_00_00_D, 44'h17_00_41_42_41_5,
		44'h20_00_81_00_03_5, 44'h21_00_80_01_80_5, 44'h1A_00_9A_9A_9A_5,
		44'h1C_3E_00_3E_3E_5, 44'h00_11_22_11_22_5, 44'h13_12_00_12_72_5,
		44'h13_9A_55_9A_00_5};
	mxu_exec i_mxu_exec (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn),
		.opValid(opValid), .opCode(opCode), .immData(immData),
		.targetAddr(targetAddr), .memRdata(memRdata), .wakeReq(wakeReq),
		.watchdogTimeout(watchdogTimeout),
		.memWe(memWe), .memWdata(memWdata), .acc(acc), .pc(pc),
		.zeroFlag(zeroFlag), .carryFlag(carryFlag),
		.halfCarryFlag(halfCarryFlag), .signedWrapFlag(signedWrapFlag),
		.watchdogExpiryFlag(watchdogExpiryFlag),
		.powerdownFlag(powerdownFlag), .globalIrqEnable(globalIrqEnable),
		.watchdogClear(watchdogClear), .sysClkGate(sysClkGate), .busy(busy));
	mxu_mem_model i_mxu_mem_model (.ref_clk(ref_clk), .ldEn(ldEn),
		.ldData(ldData), .memWe(memWe), .memWdata(memWdata),
		.memRdata(memRdata));
	// ****************************************
	// clock and hang guard
	// ****************************************
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	// the whole run needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			nMismatch++;
			giveVerdict();
		end
	end
	// one request, checked at the following falling edge
	task automatic exec(input logic [5:0] op, input logic [7:0] imm,
		input logic [10:0] tgt);
		@(posedge ref_clk);
		opValid <= 1'b1;
		opCode <= op;
		immData <= imm;
		targetAddr <= tgt;
		@(posedge ref_clk);
		opValid <= 1'b0;
		@(negedge ref_clk);
	endtask : exec
	// halt, then wake; the sleep holds busy up and refuses requests
	task automatic nap();
		logic [10:0] pcHeld;
		exec(mxu_pkg::MXU_HALT, 8'h00, 11'h000);
		`CHK(sysClkGate, 1'b1)
		`CHK({powerdownFlag, watchdogExpiryFlag}, 2'b10)
		`CHK(watchdogClear, 1'b1)
		pcHeld = pc;
		exec(mxu_pkg::MXU_NOP, 8'h00, 11'h000);
		`CHK(pc, pcHeld)
		@(posedge ref_clk);
		wakeReq <= 1'b1;
		// busy is read away from the edge that moves it
		for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge ref_clk);
		`CHK(busy, 1'b0)
		@(posedge ref_clk);
		wakeReq <= 1'b0;
	endtask : nap
	// watchdog counter runs out for one cycle
	task automatic expire();
		@(posedge ref_clk);
		watchdogTimeout <= 1'b1;
		@(posedge ref_clk);
		watchdogTimeout <= 1'b0;
		@(negedge ref_clk);
		`CHK(watchdogExpiryFlag, 1'b1)
	endtask : expire
	task automatic giveVerdict();
		$display("compared %0d mismatched %0d", nCompared, nMismatch);
		if (nMismatch == 0 && nCompared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : giveVerdict
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		@(negedge ref_clk);
		`CHK({acc, pc, zeroFlag, carryFlag, busy}, 22'h0)
		// table cases; flags carry over from row to row
		foreach (rows[k]) begin
			exec(mxu_pkg::MXU_XFER_AX, rows[k][35:28], 11'h000);
			@(posedge ref_clk);
			ldEn <= 1'b1;
			ldData <= rows[k][27:20];
			@(posedge ref_clk);
			ldEn <= 1'b0;
			exec(rows[k][41:36], rows[k][27:20], 11'h000);
			@(negedge ref_clk);
			`CHK(acc, rows[k][19:12])
			`CHK(memRdata, rows[k][11:4])
			`CHK({zeroFlag, carryFlag, halfCarryFlag, signedWrapFlag},
				rows[k][3:0])
		end
		// branches back to back, each call returns before the next call
		exec(mxu_pkg::MXU_JUMP, 8'h00, 11'h123);
		`CHK({pc, busy}, {11'h123, 1'b1})
		exec(mxu_pkg::MXU_CALL, 8'h00, 11'h200);
		`CHK(pc, 11'h200)
		exec(mxu_pkg::MXU_SUBEXIT_X, 8'h5A, 11'h000);
		`CHK({pc, acc}, {11'h124, 8'h5A})
		exec(mxu_pkg::MXU_CALL, 8'h00, 11'h300);
		exec(mxu_pkg::MXU_IRQEXIT, 8'h00, 11'h000);
		`CHK({pc, globalIrqEnable}, {11'h125, 1'b1})
		exec(mxu_pkg::MXU_CALL, 8'h00, 11'h040);
		exec(mxu_pkg::MXU_SUBEXIT, 8'h00, 11'h000);
		`CHK(pc, 11'h126)
		// expiry raised first, so halt must drop it
		expire();
		nap();
		// a repeated preclear only restarts the pair
		expire();
		exec(mxu_pkg::MXU_WDPRE1, 8'h00, 11'h000);
		exec(mxu_pkg::MXU_WDPRE1, 8'h00, 11'h000);
		`CHK({watchdogClear, powerdownFlag, watchdogExpiryFlag},
			3'b011)
		exec(mxu_pkg::MXU_WDPRE2, 8'h00, 11'h000);
		`CHK({watchdogClear, powerdownFlag, watchdogExpiryFlag},
			3'b100)
		expire();
		nap();
		expire();
		exec(mxu_pkg::MXU_WDCLR, 8'h00, 11'h000);
		`CHK({watchdogClear, powerdownFlag, watchdogExpiryFlag},
			3'b100)
		// expiry beside a clear: the expiry wins
		@(posedge ref_clk);
		opValid <= 1'b1;
		opCode <= mxu_pkg::MXU_WDCLR;
		watchdogTimeout <= 1'b1;
		@(posedge ref_clk);
		opValid <= 1'b0;
		watchdogTimeout <= 1'b0;
		@(negedge ref_clk);
		`CHK({watchdogClear, watchdogExpiryFlag}, 2'b11)
		// a low enable freezes everything
		held = {acc, pc};
		@(posedge ref_clk);
		clkEn <= 1'b0;
		exec(mxu_pkg::MXU_INC_A, 8'h00, 11'h000);
		`CHK({acc, pc}, held)
		@(posedge ref_clk);
		clkEn <= 1'b1;
		// a second reset mid-run clears the state again
		@(posedge ref_clk);
		srst <= 1'b1;
		@(posedge ref_clk);
		srst <= 1'b0;
		@(negedge ref_clk);
		`CHK({acc, pc, powerdownFlag, globalIrqEnable}, 21'h0)
		giveVerdict();
	end
endmodule : tb_mxu_exec
